// ==== design/wcs_context_switch.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_context_switch
  import wcs_pkg::*;
(
  input  wire logic        clk,         // 200 MHz clock
  input  wire logic        reset,       // Async reset, active high
  input  wire logic        sw_req,      // Start a context switch
  input  wire logic [3:0]  sw_kind,     // Switch cause
  input  wire logic [3:0]  sw_level,    // Interrupt level or xop number
  input  wire logic [15:0] branch_load_workspace_vec,    // Vector address for branch-load
  input  wire logic        fetch_req,   // Instruction fetch request
  input  wire logic        acc_req,     // General register access request
  input  wire logic [3:0]  acc_reg,     // Register number
  input  wire logic        acc_write,   // Register write
  input  wire logic        acc_byte,    // Byte operand
  input  wire logic        acc_odd,     // Odd byte select
  input  wire logic [15:0] acc_wdata,   // Register write data
  input  wire logic        st_load,     // Load new state word
  input  wire logic [15:0] st_value,    // New state word
  output logic             busy,        // Switch in progress
  output logic             acc_done,    // Request finished
  output logic [15:0]      rdata,       // Read data
  output logic [15:0]      next_instruction_pointer, // Program pointer
  output logic [15:0]      workspace_pointer,        // Register set base
  output logic [15:0]      processor_state_word,     // State word
  output logic             mem_req,     // Memory request
  output logic             mem_we,      // Memory write
  output logic [15:0]      mem_addr,    // Byte address
  output logic [1:0]       mem_lanes,   // Byte enables {even, odd}
  output logic [15:0]      mem_wdata,   // Write data
  input  wire logic        mem_ack,     // Memory cycle done
  input  wire logic [15:0] mem_rdata    // Memory read data
);
  wcs_mem_if  m ();
  wcs_state_t state;
  wcs_state_t next_state;
  logic [15:0] vec_addr;
  logic [15:0] new_wp;
  logic [15:0] old_wp;
  logic [15:0] old_pc;
  logic [15:0] old_st;
  logic        is_return_restore_workspace;
  logic        sw_start;
  logic        fetch_go;
  logic        acc_go;
  logic        in_switch;
  logic        fetch_st;
  logic [3:0]  cur_reg;
  logic        use_direct;
  logic        do_write;

  wcs_addr_former u_agu (
    .m (m)
  );

  ////////////////////////////////////////////////////////////////////////
  // Vector selection by cause
  always_comb begin
    case (wcs_kind_t'(sw_kind))
      WCS_SW_IRQ:   vec_addr = WCS_INT_VEC_BASE + {10'h000, sw_level, 2'b00};
      WCS_SW_XOP:   vec_addr = WCS_XOP_VEC_BASE + {10'h000, sw_level, 2'b00};
      WCS_SW_LOAD:  vec_addr = WCS_LOAD_VEC;
      WCS_SW_RESET: vec_addr = WCS_INT_VEC_BASE;
      WCS_SW_BRANCH_LOAD_WORKSPACE:  vec_addr = branch_load_workspace_vec;
      default:      vec_addr = WCS_INT_VEC_BASE;
    endcase
  end

  assign is_return_restore_workspace   = wcs_kind_t'(sw_kind) == WCS_SW_RETURN_RESTORE_WORKSPACE;
  assign sw_start  = (state == WCS_IDLE) && sw_req;
  assign in_switch = state != WCS_IDLE;
  assign fetch_go  = (state == WCS_IDLE) && !sw_req && fetch_req;
  assign acc_go    = (state == WCS_IDLE) && !sw_req && !fetch_req && acc_req;
  assign busy      = in_switch;

  ////////////////////////////////////////////////////////////////////////
  // Address request per state
  always_comb begin
    cur_reg    = acc_reg;
    use_direct = 1'b0;
    do_write   = 1'b0;
    mem_wdata  = acc_wdata;
    case (state)
      WCS_VEC_WP: use_direct = 1'b1;
      WCS_VEC_PC: use_direct = 1'b1;
      WCS_SV_WP: begin
        cur_reg   = WCS_SAVE_WP_REG;
        do_write  = 1'b1;
        mem_wdata = old_wp;
      end
      WCS_SV_PC: begin
        cur_reg   = WCS_SAVE_PC_REG;
        do_write  = 1'b1;
        mem_wdata = old_pc;
      end
      WCS_SV_ST: begin
        cur_reg   = WCS_SAVE_ST_REG;
        do_write  = 1'b1;
        mem_wdata = old_st;
      end
      WCS_RS_ST: cur_reg = WCS_SAVE_ST_REG;
      WCS_RS_PC: cur_reg = WCS_SAVE_PC_REG;
      WCS_RS_WP: cur_reg = WCS_SAVE_WP_REG;
      default: begin
        use_direct = fetch_go;
        do_write   = acc_go && acc_write;
      end
    endcase
  end

  assign m.base    = (state == WCS_VEC_WP) ? old_wp :
                     (state == WCS_VEC_PC) ? old_wp + WCS_PTR_STEP :
                     (state == WCS_SV_WP || state == WCS_SV_PC ||
                      state == WCS_SV_ST) ? new_wp :
                     fetch_go ? next_instruction_pointer : workspace_pointer;
  assign m.regnum  = cur_reg;
  assign m.direct  = use_direct;
  assign m.byte_op = (state == WCS_IDLE) && acc_go && acc_byte;
  assign m.odd     = acc_odd;
  assign mem_addr  = m.addr;
  assign mem_lanes = m.lanes;
  assign mem_we    = do_write;
  assign mem_req   = in_switch || fetch_go || acc_go;
  assign fetch_st  = in_switch && mem_ack;

  ////////////////////////////////////////////////////////////////////////
  // Sequence: vector fetch, three saves; or three restore fetches
  always_comb begin
    next_state = state;
    case (state)
      WCS_IDLE:   if (sw_req) next_state = is_return_restore_workspace ? WCS_RS_ST : WCS_VEC_WP;
      WCS_VEC_WP: if (mem_ack) next_state = WCS_VEC_PC;
      WCS_VEC_PC: if (mem_ack) next_state = WCS_SV_WP;
      WCS_SV_WP:  if (mem_ack) next_state = WCS_SV_PC;
      WCS_SV_PC:  if (mem_ack) next_state = WCS_SV_ST;
      WCS_SV_ST:  if (mem_ack) next_state = WCS_IDLE;
      WCS_RS_ST:  if (mem_ack) next_state = WCS_RS_PC;
      WCS_RS_PC:  if (mem_ack) next_state = WCS_RS_WP;
      WCS_RS_WP:  if (mem_ack) next_state = WCS_IDLE;
      default:    next_state = WCS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) state <= WCS_IDLE;
    else       state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured old context and vector; old_wp holds vector address first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      old_wp <= WCS_PTR_RESET;
      old_pc <= WCS_PTR_RESET;
      old_st <= WCS_ST_RESET;
      new_wp <= WCS_PTR_RESET;
    end else if (sw_start) begin
      old_wp <= vec_addr;
      old_pc <= next_instruction_pointer;
      old_st <= processor_state_word;
    end else if (state == WCS_VEC_PC && mem_ack) begin
      old_wp <= workspace_pointer;
    end else if (state == WCS_VEC_WP && mem_ack) begin
      new_wp <= mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Architectural pointers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      workspace_pointer        <= WCS_PTR_RESET;
      next_instruction_pointer <= WCS_PTR_RESET;
      processor_state_word     <= WCS_ST_RESET;
    end else begin
      if (state == WCS_SV_ST && mem_ack)
        workspace_pointer <= new_wp;
      else if (state == WCS_RS_WP && mem_ack)
        workspace_pointer <= mem_rdata;
      if ((state == WCS_VEC_PC || state == WCS_RS_PC) && mem_ack)
        next_instruction_pointer <= mem_rdata;
      else if (fetch_go && mem_ack)
        next_instruction_pointer <= next_instruction_pointer + WCS_PTR_STEP;
      if (state == WCS_RS_ST && mem_ack)
        processor_state_word <= mem_rdata;
      else if (st_load && !in_switch)
        processor_state_word <= st_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion and read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_done <= 1'b0;
      rdata    <= 16'h0000;
    end else begin
      acc_done <= ((fetch_go || acc_go) && mem_ack) || (fetch_st && next_state == WCS_IDLE);
      if ((fetch_go || acc_go) && mem_ack) rdata <= mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== design/wcs_pkg.sv ====
package wcs_pkg;
  localparam int          WCS_WORD_BITS   = 16;
  localparam int          WCS_BYTE_BITS   = 8;
  localparam int          WCS_ADDR_BITS   = 16;
  localparam logic [15:0] WCS_INT_VEC_BASE = 16'h0000; // 32 words of interrupt vectors
  localparam logic [15:0] WCS_XOP_VEC_BASE = 16'h0040; // 32 words of xop vectors
  localparam logic [15:0] WCS_LOAD_VEC     = 16'hFFFC; // Load trap vector word pair
  localparam logic [15:0] WCS_PTR_RESET    = 16'h0000;
  localparam logic [15:0] WCS_ST_RESET     = 16'h0000;
  localparam logic [3:0]  WCS_SAVE_WP_REG  = 4'hD;
  localparam logic [3:0]  WCS_SAVE_PC_REG  = 4'hE;
  localparam logic [3:0]  WCS_SAVE_ST_REG  = 4'hF;
  localparam logic [15:0] WCS_PTR_STEP     = 16'h0002;

  typedef enum logic [3:0] {
    WCS_SW_IRQ   = 4'h0,
    WCS_SW_XOP   = 4'h1,
    WCS_SW_LOAD  = 4'h2,
    WCS_SW_RESET = 4'h3,
    WCS_SW_BRANCH_LOAD_WORKSPACE  = 4'h4,
    WCS_SW_RETURN_RESTORE_WORKSPACE  = 4'h5
  } wcs_kind_t;

  typedef enum logic [8:0] {
    WCS_IDLE   = 9'h001,
    WCS_VEC_WP = 9'h002,
    WCS_VEC_PC = 9'h004,
    WCS_SV_WP  = 9'h008,
    WCS_SV_PC  = 9'h010,
    WCS_SV_ST  = 9'h020,
    WCS_RS_ST  = 9'h040,
    WCS_RS_PC  = 9'h080,
    WCS_RS_WP  = 9'h100
  } wcs_state_t;
endpackage

// ==== design/wcs_mem_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Memory request bundle between sequencer and address former
interface wcs_mem_if;
  logic [15:0] base;   // Workspace base or direct address
  logic [3:0]  regnum; // Register number
  logic        direct; // Use base as a plain address
  logic        byte_op;
  logic        odd;
  logic [15:0] addr;   // Formed byte address
  logic [1:0]  lanes;  // Byte lanes {even, odd}
  modport seq (output base, regnum, direct, byte_op, odd, input addr, lanes);
  modport agu (input base, regnum, direct, byte_op, odd, output addr, lanes);
endinterface
`default_nettype wire

// ==== design/wcs_addr_former.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_addr_former
  import wcs_pkg::*;
(
  wcs_mem_if.agu m // Address request
);
  logic [15:0] reg_addr;
  logic [15:0] word_addr;

  // Register n sits at base plus two n
  assign reg_addr  = m.base + {11'h000, m.regnum, 1'b0};
  assign word_addr = m.direct ? m.base : reg_addr;
  // Words are even; byte keeps low bit for lane choice
  assign m.addr  = {word_addr[15:1], m.byte_op & m.odd};
  assign m.lanes = m.byte_op ? {~m.odd, m.odd} : 2'b11;
endmodule
`default_nettype wire

// ==== sim/wcs_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Word memory behind the bus; answers at once or after two wait states
module wcs_mem_model (
  input  wire logic        clk,       // Clock
  input  wire logic        slow,      // Add wait states
  input  wire logic        mem_req,   // Request
  input  wire logic        mem_we,    // Write
  input  wire logic [15:0] mem_addr,  // Byte address
  input  wire logic [1:0]  mem_lanes, // Byte enables {even, odd}
  input  wire logic [15:0] mem_wdata, // Write data
  output logic             mem_ack,   // Cycle done
  output logic [15:0]      mem_rdata  // Read data
);
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_cnt = 2'h0;
  int          rd_cnt = 0;
  int          wr_cnt = 0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  // Ack one cycle; data line toggles whenever not answering
  always @(posedge clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h2)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr[15:1]];
    end
    if (mem_req && mem_ack) begin
      if (mem_we && mem_lanes[1]) mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
      if (mem_we && mem_lanes[0]) mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
      rd_cnt <= rd_cnt + (mem_we ? 0 : 1);
      wr_cnt <= wr_cnt + (mem_we ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

// ==== sim/wcs_context_switch_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module wcs_context_switch_assertions (
  input wire logic        clk,                      // Clock
  input wire logic        reset,                    // Reset
  input wire logic        sw_req,                   // Switch request
  input wire logic [3:0]  sw_kind,                  // Cause
  input wire logic [3:0]  sw_level,                 // Level
  input wire logic        fetch_req,                // Fetch
  input wire logic        acc_req,                  // Access
  input wire logic [3:0]  acc_reg,                  // Register
  input wire logic        acc_byte,                 // Byte
  input wire logic        acc_odd,                  // Odd byte
  input wire logic        busy,                     // Switching
  input wire logic [15:0] next_instruction_pointer, // Program pointer
  input wire logic [15:0] workspace_pointer,        // Base pointer
  input wire logic        mem_req,                  // Request
  input wire logic        mem_we,                   // Write
  input wire logic [15:0] mem_addr,                 // Address
  input wire logic [1:0]  mem_lanes,                // Lanes
  input wire logic        mem_ack                   // Ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [2:0] acks;
  logic [2:0] writes;
  // Memory cycles completed within one switch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acks   <= 3'h0;
      writes <= 3'h0;
    end else begin
      acks   <= busy ? acks + {2'h0, mem_req && mem_ack} : 3'h0;
      writes <= busy ? writes + {2'h0, mem_req && mem_ack && mem_we} : 3'h0;
    end
  end
  word_align_a: assert property (mem_req && mem_lanes == 2'b11 |-> !mem_addr[0])
    else $error("Word access at odd address");
  byte_lane_a: assert property (
    mem_req && mem_lanes != 2'b11 |-> mem_lanes == {!mem_addr[0], mem_addr[0]})
    else $error("Byte lane does not match address");
  fetch_step_a: assert property (
    fetch_req && !sw_req && !busy && mem_req && mem_ack |=>
    next_instruction_pointer == $past(next_instruction_pointer) + 16'h0002)
    else $error("Program pointer not stepped");
  reg_addr_a: assert property (
    acc_req && !fetch_req && !sw_req && !busy && mem_req |-> mem_addr ==
    ((workspace_pointer + {11'h000, acc_reg, 1'b0}) | {15'h0000, acc_byte && acc_odd}))
    else $error("Register address wrong");
  irq_vec_a: assert property (
    $rose(busy) && sw_kind == 4'h0 |-> mem_req && !mem_we && mem_addr == {10'h000, sw_level, 2'b00})
    else $error("Interrupt vector address wrong");
  xop_vec_a: assert property (
    $rose(busy) && sw_kind == 4'h1 |-> mem_addr == 16'h0040 + {10'h000, sw_level, 2'b00})
    else $error("Extended operation vector wrong");
  load_vec_a: assert property ($rose(busy) && sw_kind == 4'h2 |-> mem_addr == 16'hFFFC)
    else $error("Load trap vector wrong");
  switch_cnt_a: assert property (
    $fell(busy) |-> (acks == 3'h5 && writes == 3'h3) || (acks == 3'h3 && writes == 3'h0))
    else $error("Switch memory cycle count wrong");
endmodule
bind wcs_context_switch wcs_context_switch_assertions chk (.*);
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk, reset, sw_req, fetch_req, acc_req, acc_write, acc_byte, acc_odd;
  logic        st_load, busy, acc_done, mem_req, mem_we, mem_ack, slow;
  logic [3:0]  sw_kind, sw_level, acc_reg;
  logic [1:0]  mem_lanes;
  logic [15:0] branch_load_workspace_vec, acc_wdata, st_value, rdata, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] next_instruction_pointer, workspace_pointer, processor_state_word;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wcs_context_switch uut (.*);
  wcs_mem_model mdl (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results;
    end
  end
  task results;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wait_ack;
    for (int n = 0; n < 20 && mem_ack !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
  endtask
  task access(input logic [3:0] r, input logic w, b, o, input logic [15:0] wd, exp);
    {acc_reg, acc_write, acc_byte, acc_odd, acc_wdata, acc_req} = {r, w, b, o, wd, 1'b1};
    wait_ack;
    acc_req = 1'b0;
    chk({15'h0000, acc_done}, 16'h0001);
    if (!w) chk(rdata, exp);
    // Let an edge pass so back-to-back accesses show a gap in acc_req
    @(negedge clk);
  endtask
  task fetch;
    logic [15:0] p;
    p = next_instruction_pointer;
    mdl.mem[p[15:1]] = 16'hC0DE;
    fetch_req = 1'b1;
    wait_ack;
    fetch_req = 1'b0;
    chk(rdata, 16'hC0DE);
    chk(next_instruction_pointer, p + 16'h0002);
  endtask
  task regs;
    mdl.mem[2] = 16'h1234;
    mdl.mem[15] = 16'h00FF;
    access(4'h5, 1'b1, 1'b0, 1'b0, 16'hBEEF, 16'h0000);
    chk(mdl.mem[5], 16'hBEEF);
    access(4'h5, 1'b0, 1'b0, 1'b0, 16'h0000, 16'hBEEF);
    access(4'h2, 1'b1, 1'b1, 1'b1, 16'hABAB, 16'h0000);
    chk(mdl.mem[2], 16'h12AB);
    access(4'hF, 1'b1, 1'b1, 1'b0, 16'h5A5A, 16'h0000);
    chk(mdl.mem[15], 16'h5AFF);
  endtask
  task switch(input logic [3:0] k, lv, input logic [15:0] v, input logic s, output int rd, wr);
    rd = mdl.rd_cnt;
    wr = mdl.wr_cnt;
    {slow, sw_kind, sw_level, branch_load_workspace_vec, sw_req} = {s, k, lv, v, 1'b1};
    @(negedge clk);
    sw_req = 1'b0;
    for (int n = 0; n < 60 && busy !== 1'b0; n++) @(negedge clk);
    rd = mdl.rd_cnt - rd;
    wr = mdl.wr_cnt - wr;
  endtask
  task trap(input logic [3:0] k, lv, input logic [15:0] va, nwp, npc, input logic s);
    logic [15:0] owp, opc, ost;
    int          rd, wr;
    {owp, opc, ost} = {workspace_pointer, next_instruction_pointer, processor_state_word};
    mdl.mem[va[15:1]] = nwp;
    mdl.mem[va[15:1] + 1] = npc;
    switch(k, lv, va, s, rd, wr);
    chk(workspace_pointer, nwp);
    chk(next_instruction_pointer, npc);
    chk(mdl.mem[nwp[15:1] + 13], owp);
    chk(mdl.mem[nwp[15:1] + 14], opc);
    chk(mdl.mem[nwp[15:1] + 15], ost);
    chk(16'(rd * 16 + wr), 16'h0023);
  endtask
  task return_restore_workspace;
    logic [15:0] e13, e14, e15;
    int          rd, wr;
    e13 = mdl.mem[workspace_pointer[15:1] + 13];
    e14 = mdl.mem[workspace_pointer[15:1] + 14];
    e15 = mdl.mem[workspace_pointer[15:1] + 15];
    switch(4'h5, 4'h0, 16'h0000, 1'b1, rd, wr);
    chk(workspace_pointer, e13);
    chk(next_instruction_pointer, e14);
    chk(processor_state_word, e15);
    chk(16'(rd * 16 + wr), 16'h0030);
  endtask
  ////////////////////////////////////////
  initial begin
    {reset, sw_req, fetch_req, acc_req, acc_write, acc_byte, acc_odd, st_load, slow} = 9'h100;
    {sw_kind, sw_level, acc_reg, branch_load_workspace_vec, acc_wdata, st_value} = 60'h0;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    chk(workspace_pointer, 16'h0000);
    fetch;
    regs;
    {st_value, st_load} = {16'h1234, 1'b1};
    @(negedge clk);
    st_load = 1'b0;
    trap(4'h0, 4'h1, 16'h0004, 16'h0100, 16'h0200, 1'b1);
    trap(4'h1, 4'h2, 16'h0048, 16'h0300, 16'h0400, 1'b0);
    trap(4'h2, 4'h0, 16'hFFFC, 16'h0500, 16'h0600, 1'b1);
    trap(4'h4, 4'h0, 16'h2000, 16'h0700, 16'h0800, 1'b0);
    return_restore_workspace;
    trap(4'h3, 4'h0, 16'h0000, 16'h0900, 16'h0A00, 1'b1);
    fetch;
    results;
  end
endmodule
`default_nettype wire
